/* File: design/csf_forward_ctl.sv */
// forwarding arbiter for two receive ports onto the transmit stream, with status
// assumes receive ports are same-clock logic holding rx_avail until rx_take
// Overview of operation
// - replicate bit copies port 0 output to port 1
// - both outputs carry identical data when replicating
// - sync forwarding waits for all enabled ports
// - as-available sends long lines without waiting
// - as-available ignored in concat and sync packets
// - two-bit sync mode decode: off/basic/interleave/concat
// - round-robin forwards available data, no sync
// - failure flag only after a good frame
// - reading status clears the failure flag
// - locked bit shows current synchronized delivery
// - locked bit zero when sync forwarding off
// - per-port disables gate the forwarding sources
`timescale 1ns/1ps
module csf_forward_ctl #(
    parameter int DW = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // receive ports
    input wire logic [1:0] rx_avail,
    input wire logic [1:0] rx_long,
    input wire logic [1:0] rx_frame_end,
    input wire logic [DW-1:0] rx_data0,
    input wire logic [DW-1:0] rx_data1,
    output logic [1:0] rx_take,
    // transmit port 0
    output logic tx0_valid,
    output logic [1:0] tx0_src,
    output logic tx0_long,
    output logic [2*DW-1:0] tx0_data,
    // transmit port 1
    output logic tx1_valid,
    output logic [1:0] tx1_src,
    output logic tx1_long,
    output logic [2*DW-1:0] tx1_data,
    // interrupt
    output logic irq
);
    typedef enum logic [1:0] {FS_IDLE, FS_SECOND, FS_GAP} csf_state_e;

    csf_state_e state, next_state;
    logic [7:0] port_ctl, next_port_ctl;
    logic [7:0] mode_ctl, next_mode_ctl;
    logic [1:0] owed, next_owed;
    logic [1:0] last_grant, next_last_grant;
    logic ilv_second, next_ilv_second;
    logic frame_ok, next_frame_ok;
    logic fail, next_fail;
    logic locked, next_locked;
    logic [1:0] irq_sts, next_irq_sts;
    logic [1:0] irq_mask, next_irq_mask;
    logic next_irq;
    logic [7:0] next_rdata;
    logic [1:0] next_take;
    logic next_tx_valid, next_tx_long;
    logic [1:0] next_tx_src;
    logic [2*DW-1:0] next_tx_data;

    logic replicate, as_avail, rr_on, sync_on, concat;
    logic [1:0] smode, en, av, all_en, early, pick_req, pick;
    logic all_av, mismatch, check, fail_set, sts_read;
    logic [1:0] first;

    assign replicate = mode_ctl[csf_pkg::BIT_REPLICATE];
    assign as_avail = mode_ctl[csf_pkg::BIT_AS_AVAIL];
    assign smode = mode_ctl[csf_pkg::SYNC_MODE_LSB +: 2];
    assign sync_on = (smode != csf_pkg::SYNC_OFF);
    assign concat = (smode == csf_pkg::SYNC_CONCAT);
    assign rr_on = mode_ctl[csf_pkg::BIT_RR_FWD] && !sync_on;
    assign en = ~{port_ctl[csf_pkg::BIT_SECOND_DIS], port_ctl[csf_pkg::BIT_FIRST_DIS]};
    assign av = rx_avail & en;
    assign all_en = en;
    assign all_av = (en != 2'h0) && (av == all_en);
    assign mismatch = (en == 2'h3) && ((rx_long[0] != rx_long[1])
                      || (rx_frame_end[0] != rx_frame_end[1]));
    assign early = av & rx_long;
    assign pick_req = rr_on ? av : early;
    assign check = (state == FS_IDLE) && sync_on && all_av;
    assign fail_set = check && mismatch && frame_ok;
    assign sts_read = rd && (addr == csf_pkg::ADDR_SYNC_STS);

    csf_rr_pick #(.N(2)) u_pick (
        .req(pick_req),
        .last(last_grant),
        .grant(pick)
    );

    // forwarding engine
    always_comb
    begin
        next_state = state;
        next_owed = owed;
        next_last_grant = last_grant;
        next_ilv_second = ilv_second;
        next_take = 2'h0;
        next_tx_valid = 1'b0;
        next_tx_src = 2'h0;
        next_tx_long = 1'b0;
        next_tx_data = '0;
        first = 2'h0;
        case (state)
            FS_IDLE:
            begin
                if (rr_on && (pick != 2'h0))
                begin
                    first = pick;
                end
                else if (sync_on && all_av)
                begin
                    if (concat && (en == 2'h3))
                    begin
                        next_take = 2'h3;
                        next_tx_valid = 1'b1;
                        next_tx_src = 2'h3;
                        next_tx_long = rx_long[0];
                        next_tx_data = {rx_data1, rx_data0};
                        next_state = FS_GAP;
                    end
                    else if (en == 2'h3)
                    begin
                        // interleave alternates which port leads each line
                        first = ((smode == csf_pkg::SYNC_INTERLEAVE) && ilv_second)
                                ? 2'h2 : 2'h1;
                        next_owed = ~first;
                        next_ilv_second = !ilv_second;
                    end
                    else
                    begin
                        first = en;
                    end
                end
                else if (sync_on && as_avail && !concat && (pick != 2'h0))
                begin
                    first = pick;
                end
                if (first != 2'h0)
                begin
                    next_take = first;
                    next_last_grant = first;
                    next_tx_valid = 1'b1;
                    next_tx_src = first;
                    next_tx_long = first[1] ? rx_long[1] : rx_long[0];
                    next_tx_data = {{DW{1'b0}}, first[1] ? rx_data1 : rx_data0};
                    next_state = (next_owed != 2'h0) ? FS_SECOND : FS_GAP;
                end
            end
            FS_SECOND:
            begin
                next_take = owed;
                next_last_grant = owed;
                next_tx_valid = 1'b1;
                next_tx_src = owed;
                next_tx_long = owed[1] ? rx_long[1] : rx_long[0];
                next_tx_data = {{DW{1'b0}}, owed[1] ? rx_data1 : rx_data0};
                next_owed = 2'h0;
                next_state = FS_GAP;
            end
            FS_GAP:
            begin
                // sources refresh rx_avail the cycle after a take
                next_state = FS_IDLE;
            end
            default:
            begin
                next_state = FS_IDLE;
                next_owed = 2'h0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= FS_IDLE;
            owed <= 2'h0;
            last_grant <= 2'h0;
            ilv_second <= 1'b0;
            rx_take <= 2'h0;
            tx0_valid <= 1'b0;
            tx0_src <= 2'h0;
            tx0_long <= 1'b0;
            tx0_data <= '0;
            tx1_valid <= 1'b0;
            tx1_src <= 2'h0;
            tx1_long <= 1'b0;
            tx1_data <= '0;
        end
        else
        begin
            state <= next_state;
            owed <= next_owed;
            last_grant <= next_last_grant;
            ilv_second <= next_ilv_second;
            rx_take <= next_take;
            tx0_valid <= next_tx_valid;
            tx0_src <= next_tx_src;
            tx0_long <= next_tx_long;
            tx0_data <= next_tx_data;
            tx1_valid <= replicate && next_tx_valid;
            tx1_src <= replicate ? next_tx_src : 2'h0;
            tx1_long <= replicate && next_tx_long;
            tx1_data <= replicate ? next_tx_data : '0;
        end
    end

    // registers, sync status and interrupt
    always_comb
    begin
        next_port_ctl = port_ctl;
        next_mode_ctl = mode_ctl;
        next_irq_mask = irq_mask;
        next_frame_ok = frame_ok;
        if (wr && (addr == csf_pkg::ADDR_PORT_CTL))
        begin
            next_port_ctl = wdata & csf_pkg::PORT_WMASK;
        end
        if (wr && (addr == csf_pkg::ADDR_MODE_CTL))
        begin
            next_mode_ctl = wdata & csf_pkg::MODE_WMASK;
        end
        if (wr && (addr == csf_pkg::ADDR_IRQ_MASK))
        begin
            next_irq_mask = wdata[1:0];
        end
        if (!sync_on || (check && mismatch))
        begin
            next_frame_ok = 1'b0;
        end
        else if (check && rx_frame_end[0] && !(concat && (en != 2'h3)))
        begin
            next_frame_ok = 1'b1;
        end
        next_fail = (fail && !sts_read) || fail_set;
        next_locked = sync_on && next_frame_ok;
        next_irq_sts = irq_sts;
        if (wr && (addr == csf_pkg::ADDR_IRQ_STS))
        begin
            next_irq_sts = irq_sts & ~wdata[1:0];
        end
        next_irq_sts[csf_pkg::IRQ_FAIL] = next_irq_sts[csf_pkg::IRQ_FAIL] || fail_set;
        next_irq_sts[csf_pkg::IRQ_LOCK] = next_irq_sts[csf_pkg::IRQ_LOCK]
                                          || (next_locked && !locked);
        next_irq = |(next_irq_sts & next_irq_mask);
        next_rdata = 8'h00;
        if (rd)
        begin
            case (addr)
                csf_pkg::ADDR_PORT_CTL: next_rdata = port_ctl;
                csf_pkg::ADDR_MODE_CTL: next_rdata = mode_ctl;
                csf_pkg::ADDR_SYNC_STS:
                begin
                    next_rdata[csf_pkg::BIT_SYNC_FAIL] = fail;
                    next_rdata[csf_pkg::BIT_SYNC_LOCK] = locked && sync_on;
                end
                csf_pkg::ADDR_IRQ_STS: next_rdata = {6'h00, irq_sts};
                csf_pkg::ADDR_IRQ_MASK: next_rdata = {6'h00, irq_mask};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            port_ctl <= csf_pkg::PORT_RESET;
            mode_ctl <= csf_pkg::MODE_RESET;
            irq_mask <= csf_pkg::IRQ_RESET;
            irq_sts <= csf_pkg::IRQ_RESET;
            frame_ok <= 1'b0;
            fail <= 1'b0;
            locked <= 1'b0;
            irq <= 1'b0;
            rdata <= 8'h00;
        end
        else
        begin
            port_ctl <= next_port_ctl;
            mode_ctl <= next_mode_ctl;
            irq_mask <= next_irq_mask;
            irq_sts <= next_irq_sts;
            frame_ok <= next_frame_ok;
            fail <= next_fail;
            locked <= next_locked;
            irq <= next_irq;
            rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_sync_wait_idle;
        (state == FS_IDLE) && sync_on && !as_avail;
    endsequence

    sequence s_early_line;
        (state == FS_IDLE) && sync_on && as_avail && !concat && !all_av && (early != 2'h0);
    endsequence

    a_replicate_copy: assert property ($past(replicate) |-> (tx1_valid == tx0_valid)
        && (tx1_data == tx0_data) && (tx1_src == tx0_src) && (tx1_long == tx0_long))
        else $error("replicated output differs from port 0");
    a_replicate_off: assert property (!$past(replicate) |-> !tx1_valid)
        else $error("port 1 active without replicate");
    a_sync_waits_all: assert property (s_sync_wait_idle ##1 tx0_valid |-> $past(all_av))
        else $error("synchronized line sent before all ports ready");
    a_as_avail_send: assert property (s_early_line |=> tx0_valid && tx0_long)
        else $error("available long line not forwarded");
    a_concat_holds: assert property ((state == FS_IDLE) && concat && !all_av |=> !tx0_valid)
        else $error("concat mode forwarded early");
    a_rr_forward: assert property ((state == FS_IDLE) && rr_on && (av != 2'h0)
        |=> tx0_valid && (tx0_src != 2'h3) ##1 !tx0_valid)
        else $error("round robin did not forward one packet");
    a_fail_after_frame: assert property ($rose(fail) |-> $past(frame_ok))
        else $error("failure flagged before any good frame");
    a_fail_read_clear: assert property (sts_read && !fail_set |=> !fail)
        else $error("failure flag survived a status read");
    a_lock_off: assert property (!sync_on |=> !locked)
        else $error("locked while sync forwarding off");
    a_take_enabled: assert property (rx_take[0] |-> $past(en[0]))
        else $error("disabled port was taken");
    a_reserved_zero: assert property (rd && (addr == csf_pkg::ADDR_MODE_CTL)
        |=> (rdata[5:4] == 2'h0) && !rdata[1])
        else $error("reserved mode bits read nonzero");
endmodule : csf_forward_ctl

/* File: design/csf_pkg.sv */
// constants for the forwarding arbiter: register map, field positions, reset values
// assumes an 8-bit register port with byte addresses as listed here
package csf_pkg;
    // register addresses
    localparam logic [7:0] ADDR_PORT_CTL = 8'h20;
    localparam logic [7:0] ADDR_MODE_CTL = 8'h21;
    localparam logic [7:0] ADDR_SYNC_STS = 8'h22;
    localparam logic [7:0] ADDR_IRQ_STS = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h31;
    // forwarding_mode_control fields
    localparam int BIT_REPLICATE = 7;
    localparam int BIT_AS_AVAIL = 6;
    localparam int SYNC_MODE_LSB = 2;
    localparam int BIT_RR_FWD = 0;
    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam logic [7:0] MODE_WMASK = 8'hcd;
    // port control fields
    localparam int BIT_SECOND_DIS = 5;
    localparam int BIT_FIRST_DIS = 4;
    localparam logic [7:0] PORT_RESET = 8'h30;
    localparam logic [7:0] PORT_WMASK = 8'h30;
    // forwarding_sync_status fields
    localparam int BIT_SYNC_FAIL = 2;
    localparam int BIT_SYNC_LOCK = 0;
    // interrupt status and mask fields
    localparam int IRQ_FAIL = 0;
    localparam int IRQ_LOCK = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // synchronized forwarding mode codes
    localparam logic [1:0] SYNC_OFF = 2'h0;
    localparam logic [1:0] SYNC_BASIC = 2'h1;
    localparam logic [1:0] SYNC_INTERLEAVE = 2'h2;
    localparam logic [1:0] SYNC_CONCAT = 2'h3;
endpackage : csf_pkg

/* File: design/csf_rr_pick.sv */
// round-robin picker: one-hot grant among requests, starting after the last grant
// assumes last is one-hot or zero; purely combinational
`timescale 1ns/1ps
module csf_rr_pick #(
    parameter int N = 2
) (
    // requests and history
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] last,
    // result
    output logic [N-1:0] grant
);
    logic [2*N-1:0] dbl;
    logic [2*N-1:0] base;
    logic [2*N-1:0] masked;
    logic [2*N-1:0] low;

    always_comb
    begin
        dbl = {req, req};
        base = (last == '0) ? {{N{1'b0}}, 1'b1, {(N-1){1'b0}}} : {{N{1'b0}}, last};
        // keep only positions strictly above the last grant
        masked = dbl & ~((base << 1) - {{(2*N-1){1'b0}}, 1'b1});
        low = masked & (~masked + {{(2*N-1){1'b0}}, 1'b1});
        grant = low[N-1:0] | low[2*N-1:N];
    end
endmodule : csf_rr_pick

/* File: verif/csf_rx_sink.sv */
// downstream sink model: records the packets seen on both transmit ports
// assumes the arbiter's clock; it never stalls the stream, as the real consumer cannot
`timescale 1ns/1ps
module csf_rx_sink (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // transmit port 0
    input wire logic tx0_valid,
    input wire logic [1:0] tx0_src,
    input wire logic [15:0] tx0_data,
    // transmit port 1
    input wire logic tx1_valid,
    input wire logic [1:0] tx1_src,
    input wire logic [15:0] tx1_data,
    // observations
    output int n0,
    output int n1,
    output logic [3:0] hist,
    output logic [15:0] last,
    output logic rep_bad
);
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            n0 <= 0;
            n1 <= 0;
            hist <= 4'h0;
            last <= 16'h0000;
            rep_bad <= 1'b0;
        end
        else
        begin
            if (tx0_valid)
            begin
                n0 <= n0 + 1;
                hist <= {hist[1:0], tx0_src};
                last <= tx0_data;
            end
            if (tx1_valid)
            begin
                n1 <= n1 + 1;
            end
            // a copy must match the primary's source and data in the same cycle
            if (tx1_valid && (!tx0_valid || tx1_src !== tx0_src || tx1_data !== tx0_data))
            begin
                rep_bad <= 1'b1;
            end
        end
    end
endmodule : csf_rx_sink

/* File: verif/csi_forwarding_control_tb_top.sv */
// testbench: registers, round robin, synchronized modes, status and replicate
// assumes one 20 MHz clock; the bench plays both receive ports
`timescale 1ns/1ps
module csi_forwarding_control_tb_top;
    logic clk, rst, wr, rd, irq, tx0_valid, tx1_valid, tx0_long, tx1_long, rep_bad;
    logic [7:0] addr, wdata, rdata, rx_data0, rx_data1, v;
    logic [1:0] rx_avail, rx_long, rx_frame_end, rx_take, tx0_src, tx1_src;
    logic [15:0] tx0_data, tx1_data, last;
    logic [3:0] hist;
    int n0, n1, b, b1, n_mismatch, n_checks;

    csf_forward_ctl #(.DW(8)) dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .rx_avail(rx_avail), .rx_long(rx_long),
        .rx_frame_end(rx_frame_end), .rx_data0(rx_data0), .rx_data1(rx_data1),
        .rx_take(rx_take), .tx0_valid(tx0_valid), .tx0_src(tx0_src), .tx0_long(tx0_long),
        .tx0_data(tx0_data), .tx1_valid(tx1_valid), .tx1_src(tx1_src), .tx1_long(tx1_long),
        .tx1_data(tx1_data), .irq(irq));

    csf_rx_sink sink_u (.clk(clk), .rst(rst), .tx0_valid(tx0_valid), .tx0_src(tx0_src),
        .tx0_data(tx0_data), .tx1_valid(tx1_valid), .tx1_src(tx1_src), .tx1_data(tx1_data),
        .n0(n0), .n1(n1), .hist(hist), .last(last), .rep_bad(rep_bad));

    always #25 clk = ~clk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd_reg

    task automatic wait2();
        repeat (2) @(posedge clk);
        #1;
    endtask : wait2

    // present packets, then let the engine act; a taken packet is withdrawn next cycle
    // and its data lines stop showing the old value
    task automatic offer(input logic [1:0] av, input logic [1:0] lg, input logic [1:0] fe,
        input logic [7:0] d0, input logic [7:0] d1);
        @(posedge clk);
        rx_avail <= av;
        rx_long <= lg;
        rx_frame_end <= fe;
        rx_data0 <= d0;
        rx_data1 <= d1;
        repeat (8)
        begin
            @(posedge clk);
            if (rx_take[0])
            begin
                rx_avail[0] <= 1'b0;
                rx_data0 <= ~rx_data0;
            end
            if (rx_take[1])
            begin
                rx_avail[1] <= 1'b0;
                rx_data1 <= ~rx_data1;
            end
        end
        #1;
    endtask : offer

    task automatic idle();
        @(posedge clk);
        rx_avail <= 2'b00;
        rx_data0 <= ~rx_data0;
        rx_data1 <= ~rx_data1;
    endtask : idle

    task automatic t_regs();
        rd_reg(8'h20);
        chk(16'(v), 16'h0030, "port ctl reset");
        rd_reg(8'h21);
        chk(16'(v), 16'h0001, "mode reset");
        rd_reg(8'h22);
        chk(16'(v), 16'h0000, "status reset");
        rd_reg(8'h40);
        chk(16'(v), 16'h0000, "unmapped read");
        wr_reg(8'h21, 8'hfe);
        rd_reg(8'h21);
        chk(16'(v), 16'h00cc, "mode reserved bits");
        wr_reg(8'h21, 8'h01);
        $display("test regs done");
    endtask : t_regs

    task automatic t_rr();
        wr_reg(8'h20, 8'h00);
        b = n0;
        offer(2'b11, 2'b11, 2'b00, 8'h11, 8'h22);
        chk(16'(n0 - b), 16'h0002, "rr count");
        chk(16'(hist[3:2] | hist[1:0]), 16'h0003, "rr both sources");
        wr_reg(8'h20, 8'h20);
        offer(2'b10, 2'b10, 2'b00, 8'h33, 8'h44);
        chk(16'(rx_avail), 16'h0002, "disabled port taken");
        chk(16'(n0 - b), 16'h0002, "disabled port forwarded");
        idle();
        $display("test round robin done");
    endtask : t_rr

    task automatic t_sync();
        wr_reg(8'h20, 8'h00);
        wr_reg(8'h21, 8'h04);
        b = n0;
        offer(2'b01, 2'b01, 2'b00, 8'h01, 8'h02);
        chk(16'(n0 - b), 16'h0000, "basic waited");
        offer(2'b11, 2'b11, 2'b00, 8'h01, 8'h02);
        chk(16'(n0 - b), 16'h0002, "basic pair");
        chk(16'(hist), 16'h0006, "basic order");
        offer(2'b11, 2'b01, 2'b00, 8'h03, 8'h04);
        idle();
        rd_reg(8'h22);
        chk(16'(v), 16'h0000, "fail before frame");
        offer(2'b11, 2'b00, 2'b11, 8'h05, 8'h06);
        rd_reg(8'h22);
        chk(16'(v), 16'h0001, "locked");
        chk(16'(irq), 16'h0000, "irq masked");
        wr_reg(8'h31, 8'h03);
        wait2();
        chk(16'(irq), 16'h0001, "irq lock");
        wr_reg(8'h30, 8'h02);
        wait2();
        chk(16'(irq), 16'h0000, "irq cleared");
        offer(2'b11, 2'b01, 2'b00, 8'h07, 8'h08);
        idle();
        rd_reg(8'h22);
        chk(16'(v & 8'hfe), 16'h0004, "fail set");
        chk(16'(irq), 16'h0001, "irq fail");
        rd_reg(8'h22);
        chk(16'(v & 8'hfe), 16'h0000, "fail read clear");
        wr_reg(8'h30, 8'h01);
        wait2();
        chk(16'(irq), 16'h0000, "irq fail cleared");
        wr_reg(8'h21, 8'h44);
        b = n0;
        offer(2'b01, 2'b01, 2'b00, 8'h09, 8'h0a);
        chk(16'(n0 - b), 16'h0001, "as available line");
        offer(2'b01, 2'b00, 2'b00, 8'h0b, 8'h0c);
        chk(16'(n0 - b), 16'h0001, "as available sync pkt");
        idle();
        wr_reg(8'h21, 8'h08);
        b = n0;
        offer(2'b11, 2'b11, 2'b00, 8'h0d, 8'h0e);
        chk(16'(n0 - b), 16'h0002, "interleave pair");
        b1 = int'(hist);
        offer(2'b11, 2'b00, 2'b11, 8'h0f, 8'h10);
        chk(16'(hist), 16'({b1[1:0], b1[3:2]}), "interleave alternates");
        rd_reg(8'h22);
        chk(16'(v), 16'h0001, "locked interleave");
        wr_reg(8'h21, 8'h00);
        rd_reg(8'h22);
        chk(16'(v & 8'h01), 16'h0000, "locked when off");
        $display("test sync done");
    endtask : t_sync

    task automatic t_concat();
        wr_reg(8'h21, 8'h0c);
        b1 = n1;
        offer(2'b11, 2'b11, 2'b00, 8'haa, 8'h55);
        chk(last, 16'h55aa, "concat data");
        chk(16'(hist[1:0]), 16'h0003, "concat source");
        chk(16'(n1 - b1), 16'h0000, "no copy");
        wr_reg(8'h21, 8'h8c);
        offer(2'b11, 2'b11, 2'b00, 8'h12, 8'h34);
        chk(16'(n1 - b1), 16'h0001, "copy");
        chk(16'(rep_bad), 16'h0000, "copy equal");
        wr_reg(8'h21, 8'h4c);
        b = n0;
        offer(2'b01, 2'b01, 2'b00, 8'h56, 8'h78);
        chk(16'(n0 - b), 16'h0000, "as available in concat");
        idle();
        $display("test concat done");
    endtask : t_concat

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    initial
    begin
        #200000;
        n_mismatch++;
        summarize();
    end

    initial
    begin
        {clk, wr, rd, addr, wdata, rx_avail, rx_long, rx_frame_end} = '0;
        {rx_data0, rx_data1, n_mismatch, n_checks} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_rr();
        t_sync();
        t_concat();
        summarize();
    end
endmodule : csi_forwarding_control_tb_top
